// File: rtl/txsr_pkg.sv
/*
  Constants for the transmit status reporting block.
  Assumes a single 250 MHz clock and a 16-bit indirect register port.
*/
package txsr_pkg;
  localparam int          CLK_MHZ        = 250;
  localparam int          DIST_RATE_MHZ  = 10;
  localparam int          DIST_DIV       = CLK_MHZ / DIST_RATE_MHZ;
  localparam int          MAX_ATTEMPTS   = 16;
  localparam int          DIST_W         = 10;
  localparam logic [6:0]  IDX_STATUS     = 7'h00;
  localparam logic [6:0]  IDX_IBASE_LO   = 7'h01;
  localparam logic [6:0]  IDX_IBASE_HI   = 7'h02;
  localparam logic [6:0]  IDX_MASK       = 7'h03;
  localparam logic [6:0]  IDX_MISC       = 7'h04;
  localparam logic [6:0]  IDX_RINGLEN    = 7'h06;
  localparam logic [6:0]  IDX_MODE       = 7'h0f;
  localparam logic [6:0]  IDX_IBASE      = 7'h10;
  localparam logic [6:0]  IDX_CXBA       = 7'h14;
  localparam logic [6:0]  IDX_TXRING     = 7'h1e;
  localparam logic [6:0]  IDX_NXDA       = 7'h20;
  localparam logic [6:0]  IDX_CXDA       = 7'h22;
  localparam logic [6:0]  IDX_NNXDA      = 7'h26;
  localparam logic [6:0]  IDX_CXBC       = 7'h2a;
  localparam logic [6:0]  IDX_POLL       = 7'h2e;
  localparam logic [6:0]  IDX_PINT       = 7'h2f;
  localparam logic [6:0]  IDX_PXDA       = 7'h3c;
  localparam logic [6:0]  IDX_PXBC       = 7'h3e;
  localparam int          BIT_BUF_ERR    = 15;
  localparam int          BIT_UNDERFLOW  = 14;
  localparam int          BIT_RSVD_ZERO  = 13;
  localparam int          BIT_LATE_COLL  = 12;
  localparam int          BIT_CARR_LOSS  = 11;
  localparam int          BIT_RETRY_ERR  = 10;
  localparam int          BIT_TX_ON      = 4;
  localparam int          BIT_TX_DEMAND  = 3;
  localparam int          BIT_NO_RETRY   = 5;
  localparam int          BIT_TP_SEL     = 7;
  localparam logic [15:0] STATUS_RST     = 16'h0000;
  localparam logic [15:0] MODE_RST       = 16'h0000;
  localparam logic [6:0]  PTR_RST        = 7'h00;
endpackage : txsr_pkg

// File: rtl/txsr_sync.sv
/*
  Two-stage synchroniser for a group of level inputs.
  Assumes inputs are static long enough to be sampled by ref_clk.
*/
`timescale 1ns/100ps
module txsr_sync
#(
  parameter int W = 1
)
(
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // Only the second stage is read outside this module.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : txsr_sync

// File: rtl/txsr_top.sv
/*
  Transmit status reporting: descriptor error flags, fault-distance
  counter and the indirect pointer/data register port.
  Assumes the transmit engine signals frame events on ref_clk and that
  medium status pins are asynchronous.
*/
`timescale 1ns/100ps
// Behaviour
// - FIFO empty before frame end sets the underflow flag and clears transmit_on.
// - Descriptor status bit 13 is always written as zero.
// - A collision after the slot time sets late collision and ends retries.
// - In AUI mode carrier loss sets carrier loss yet the frame is sent to its end.
// - In twisted-pair mode link fail of the transceiver sets carrier loss.
// - Sixteen failed attempts from collisions set the retry error flag.
// - With disable_retry set, one failed attempt sets the retry error flag.
// - A 10 MHz counter runs from transmit start to collision or a fall of the carrier pin into bits 9-0.
// - The pointer port selects a register index; the data port reads or writes it.
// - Indices 1 and 2 alias the low and high halves of the init base at 16 and 17.
// - A buffer error during chaining also reports underflow.
module txsr_top
  import txsr_pkg::*;
#(
  parameter int DIV       = DIST_DIV,
  parameter int ATTEMPTS  = MAX_ATTEMPTS
)
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        ptr_wr,
  input  wire logic        data_wr,
  input  wire logic        data_rd,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  output logic             rvalid,
  input  wire logic        tx_start,
  input  wire logic        tx_frame_end,
  input  wire logic        tx_fifo_empty,
  input  wire logic        slot_elapsed,
  input  wire logic        chain_buf_miss,
  input  wire logic        collision_pin,
  input  wire logic        carrier_pin,
  input  wire logic        link_fail_pin,
  output logic             retransmit,
  output logic             tx_abort,
  output logic             status_wr,
  output logic      [15:0] status_word,
  output logic             transmit_on
);
  typedef enum logic [1:0]
  {
    TXSR_IDLE = 2'b00,
    TXSR_SEND = 2'b01,
    TXSR_DONE = 2'b10
  } txsr_state_t;

  txsr_state_t       state_r;
  logic [6:0]        ptr_r;
  logic [15:0]       mode_r;
  logic [15:0]       mask_r;
  logic [15:0]       misc_r;
  logic [15:0]       ringlen_r;
  logic [15:0]       poll_r;
  logic [31:0]       ibase_r;
  logic [31:0]       wide_r [0:8];
  logic [31:0]       pint_r;
  logic [7:0]        div_r;
  logic              tick;
  logic [DIST_W-1:0] dist_r;
  logic              dist_run_r;
  logic [4:0]        tries_r;
  logic              underflow_r;
  logic              buf_err_r;
  logic              late_coll_r;
  logic              carr_loss_r;
  logic              retry_err_r;
  logic              coll_prev_r;
  logic              coll_rise;
  logic [2:0]        med;
  logic              coll_s;
  logic              car_s;
  logic              lf_s;
  logic              car_prev_r;
  logic              transmit_on_set;
  logic [15:0]       rd_nxt;
  logic [3:0]        widx;
  logic              wsel;
  logic              whi;

  txsr_sync #(.W(3)) u_sync
  (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in ({collision_pin, carrier_pin, link_fail_pin}),
    .sync_out (med)
  );

  assign coll_s = med[2];
  assign car_s  = med[1];
  assign lf_s   = med[0];
  assign transmit_on_set = data_wr && ptr_r == IDX_STATUS && wdata[BIT_TX_ON];
  // A collision holds for several cycles; only its onset counts an attempt.
  assign coll_rise = coll_s && !coll_prev_r;

  // Map the wide transmit registers onto a small array by index.
  always_comb
  begin
    wsel = 1'b1;
    widx = 4'h0;
    whi  = ptr_r[0];
    if (ptr_r[6:1] == IDX_CXBA[6:1])
      widx = 4'h0;
    else if (ptr_r[6:1] == IDX_TXRING[6:1])
      widx = 4'h1;
    else if (ptr_r[6:1] == IDX_NXDA[6:1])
      widx = 4'h2;
    else if (ptr_r[6:1] == IDX_CXDA[6:1])
      widx = 4'h3;
    else if (ptr_r[6:1] == IDX_NNXDA[6:1])
      widx = 4'h4;
    else if (ptr_r[6:1] == IDX_CXBC[6:1])
      widx = 4'h5;
    else if (ptr_r[6:1] == IDX_PXDA[6:1])
      widx = 4'h6;
    else if (ptr_r[6:1] == IDX_PXBC[6:1])
      widx = 4'h7;
    else
      wsel = 1'b0;
  end

  // Pointer port holds the selected index.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ptr_r <= PTR_RST;
    else if (ptr_wr)
      ptr_r <= wdata[6:0];
  end

  // Software-written configuration registers.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r    <= MODE_RST;
      mask_r    <= 16'h0000;
      misc_r    <= 16'h0000;
      ringlen_r <= 16'h0000;
      poll_r    <= 16'h0000;
      ibase_r   <= 32'h0000_0000;
      pint_r    <= 32'h0000_0000;
      for (int i = 0; i < 9; i++)
        wide_r[i] <= 32'h0000_0000;
    end
    else if (data_wr)
    begin
      if (ptr_r == IDX_IBASE_LO || ptr_r == IDX_IBASE)
        ibase_r[15:0] <= wdata;
      else if (ptr_r == IDX_IBASE_HI || ptr_r == IDX_IBASE + 7'h01)
        ibase_r[31:16] <= wdata;
      else if (ptr_r == IDX_MASK)
        mask_r <= wdata;
      else if (ptr_r == IDX_MISC)
        misc_r <= wdata;
      else if (ptr_r == IDX_RINGLEN)
        ringlen_r <= wdata;
      else if (ptr_r == IDX_MODE)
        mode_r <= wdata;
      else if (ptr_r == IDX_POLL)
        poll_r <= wdata;
      else if (ptr_r == IDX_PINT)
        pint_r[15:0] <= wdata;
      else if (ptr_r == IDX_PINT + 7'h01)
        pint_r[31:16] <= wdata;
      else if (wsel && !whi)
        wide_r[widx][15:0] <= wdata;
      else if (wsel)
        wide_r[widx][31:16] <= wdata;
    end
  end

  // Read mux; unmapped indices read as zero.
  always_comb
  begin
    rd_nxt = 16'h0000;
    if (ptr_r == IDX_STATUS)
      rd_nxt = {11'h000, transmit_on, 4'h0};
    else if (ptr_r == IDX_IBASE_LO || ptr_r == IDX_IBASE)
      rd_nxt = ibase_r[15:0];
    else if (ptr_r == IDX_IBASE_HI || ptr_r == IDX_IBASE + 7'h01)
      rd_nxt = ibase_r[31:16];
    else if (ptr_r == IDX_MASK)
      rd_nxt = mask_r;
    else if (ptr_r == IDX_MISC)
      rd_nxt = misc_r;
    else if (ptr_r == IDX_RINGLEN)
      rd_nxt = ringlen_r;
    else if (ptr_r == IDX_MODE)
      rd_nxt = mode_r;
    else if (ptr_r == IDX_POLL)
      rd_nxt = poll_r;
    else if (ptr_r == IDX_PINT)
      rd_nxt = pint_r[15:0];
    else if (ptr_r == IDX_PINT + 7'h01)
      rd_nxt = pint_r[31:16];
    else if (ptr_r == IDX_CXBC && state_r != TXSR_IDLE)
      rd_nxt = status_word;
    else if (wsel && !whi)
      rd_nxt = wide_r[widx][15:0];
    else if (wsel)
      rd_nxt = wide_r[widx][31:16];
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= data_rd;
      if (data_rd)
        rdata <= rd_nxt;
    end
  end

  // The 10 MHz time base is a strobe from a free-running divider.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      div_r <= 8'h00;
    else if (tick)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end
  assign tick = (div_r == 8'(DIV - 1));

  // Fault-distance counter; it stops on collision or a fall of the carrier pin, not on link fail.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dist_r     <= '0;
      dist_run_r <= 1'b0;
    end
    else if (tx_start)
    begin
      dist_r     <= '0;
      dist_run_r <= 1'b1;
    end
    else if (dist_run_r && (coll_s || (car_prev_r && !car_s)))
      dist_run_r <= 1'b0;
    else if (dist_run_r && tick && state_r == TXSR_SEND && dist_r != '1)
      dist_r <= dist_r + 1'b1;
  end

  // Frame state, retry counting and error flags.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r     <= TXSR_IDLE;
      tries_r     <= 5'h00;
      underflow_r <= 1'b0;
      buf_err_r   <= 1'b0;
      late_coll_r <= 1'b0;
      carr_loss_r <= 1'b0;
      retry_err_r <= 1'b0;
      car_prev_r  <= 1'b0;
      coll_prev_r <= 1'b0;
      retransmit <= 1'b0;
      tx_abort   <= 1'b0;
      status_wr  <= 1'b0;
    end
    else
    begin
      car_prev_r  <= car_s;
      coll_prev_r <= coll_s;
      retransmit <= 1'b0;
      tx_abort   <= 1'b0;
      status_wr  <= 1'b0;
      case (state_r)
        TXSR_IDLE:
        begin
          if (tx_start)
          begin
            state_r <= TXSR_SEND;
            tries_r <= 5'h01;
            underflow_r <= 1'b0;
            buf_err_r   <= 1'b0;
            late_coll_r <= 1'b0;
            carr_loss_r <= 1'b0;
            retry_err_r <= 1'b0;
          end
        end
        TXSR_SEND:
        begin
          if (!mode_r[BIT_TP_SEL] && car_prev_r && !car_s)
            carr_loss_r <= 1'b1;
          if (mode_r[BIT_TP_SEL] && lf_s)
            carr_loss_r <= 1'b1;
          if (chain_buf_miss)
          begin
            buf_err_r   <= 1'b1;
            underflow_r <= 1'b1;
            tx_abort <= 1'b1;
            state_r  <= TXSR_DONE;
          end
          else if (tx_fifo_empty && !tx_frame_end)
          begin
            underflow_r <= 1'b1;
            tx_abort <= 1'b1;
            state_r  <= TXSR_DONE;
          end
          else if (coll_rise && slot_elapsed)
          begin
            late_coll_r <= 1'b1;
            tx_abort <= 1'b1;
            state_r  <= TXSR_DONE;
          end
          else if (coll_rise)
          begin
            if (mode_r[BIT_NO_RETRY] || tries_r == 5'(ATTEMPTS))
            begin
              retry_err_r <= 1'b1;
              tx_abort <= 1'b1;
              state_r  <= TXSR_DONE;
            end
            else
            begin
              tries_r    <= tries_r + 5'h01;
              retransmit <= 1'b1;
            end
          end
          else if (tx_frame_end)
            state_r <= TXSR_DONE;
        end
        TXSR_DONE:
        begin
          status_wr <= 1'b1;
          state_r   <= TXSR_IDLE;
        end
        default:
          state_r <= TXSR_IDLE;
      endcase
    end
  end

  // Status word presented with the descriptor write-back.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      status_word <= 16'h0000;
    else
    begin
      status_word              <= 16'h0000;
      status_word[BIT_BUF_ERR]   <= buf_err_r;
      status_word[BIT_UNDERFLOW] <= underflow_r;
      status_word[BIT_RSVD_ZERO] <= 1'b0;
      status_word[BIT_LATE_COLL] <= late_coll_r;
      status_word[BIT_CARR_LOSS] <= carr_loss_r;
      status_word[BIT_RETRY_ERR] <= retry_err_r;
      status_word[DIST_W-1:0]    <= dist_r;
    end
  end

  // Software may start the transmitter; underflow stops it.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      transmit_on <= 1'b0;
    else if (state_r == TXSR_SEND && (chain_buf_miss ||
             (tx_fifo_empty && !tx_frame_end)))
      transmit_on <= 1'b0;
    else if (transmit_on_set)
      transmit_on <= 1'b1;
  end
endmodule : txsr_top

// File: testbench/txsr_assertions.sv
/*
  Port checker for the transmit status block.
  Assumes it is bound to txsr_top and shares its clock and reset.
*/
`timescale 1ns/100ps
module txsr_assertions
#(
  parameter int DIV      = 25,
  parameter int ATTEMPTS = 16
)
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        data_rd,
  input wire logic        rvalid,
  input wire logic        tx_start,
  input wire logic        retransmit,
  input wire logic        tx_abort,
  input wire logic        status_wr,
  input wire logic [15:0] status_word,
  input wire logic        transmit_on
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (data_rd |=> rvalid)
    else $error("read gave no answer");
  a_quiet_read: assert property (!data_rd |=> !rvalid)
    else $error("answer without a read");
  a_res_zero: assert property (status_wr |-> !status_word[13])
    else $error("reserved status bit set");
  a_underflow_flag_txoff: assert property (
    status_wr && status_word[14] |-> !transmit_on)
    else $error("transmitter left on after underflow");
  a_buffer_error_flag_underflow_flag: assert property (
    status_wr && status_word[15] |-> status_word[14])
    else $error("buffer error without underflow");
  a_abort_status: assert property (tx_abort |=> status_wr)
    else $error("abort not followed by status");
  a_late_noretry: assert property (
    status_wr && status_word[12] |->
    !retransmit && !$past(retransmit) && !$past(retransmit, 2))
    else $error("retry around a late collision");
  a_retry_abort: assert property (
    status_wr && status_word[10] |-> $past(tx_abort))
    else $error("retry error without abort");
  a_status_hold: assert property (
    status_wr && !tx_start |=> $stable(status_word))
    else $error("status word moved after write");
endmodule : txsr_assertions

bind txsr_top txsr_assertions #(.DIV(DIV), .ATTEMPTS(ATTEMPTS)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .data_rd(data_rd),
  .rvalid(rvalid), .tx_start(tx_start), .retransmit(retransmit),
  .tx_abort(tx_abort), .status_wr(status_wr),
  .status_word(status_word), .transmit_on(transmit_on));

// File: testbench/txsr_medium.sv
/*
  Medium model: collision, carrier and link fail levels.
  Assumes the bench calls its tasks just after a clock edge.
*/
`timescale 1ns/100ps
module txsr_medium
(
  input  wire logic ref_clk,
  output logic      collision_pin,
  output logic      carrier_pin,
  output logic      link_fail_pin
);
  int hold = 0;
  initial
  begin
    collision_pin = 1'b0;
    carrier_pin   = 1'b0;
    link_fail_pin = 1'b0;
  end
  // A burst shorter than the synchroniser could be missed.
  always @(posedge ref_clk)
  begin
    if (hold == 1)
      collision_pin <= 1'b0;
    if (hold > 0)
      hold <= hold - 1;
  end
  task collide();
    collision_pin = 1'b1;
    hold = 4;
  endtask : collide
  task set_carrier(input logic v);
    carrier_pin = v;
  endtask : set_carrier
  task set_link(input logic v);
    link_fail_pin = v;
  endtask : set_link
endmodule : txsr_medium

// File: testbench/transmit_status_reporting_bench.sv
/*
  Bench for txsr_top: register port and transmit status cases.
  Assumes the medium model txsr_medium and a 250 MHz clock.
*/
`timescale 1ns/100ps
module transmit_status_reporting_bench
  import txsr_pkg::*;
;
  typedef struct {logic [15:0] m; logic [15:0] v; int lo; int hi;} txsr_exp_t;
  localparam int D = 4;
  localparam logic [6:0] WI[4] = '{IDX_IBASE, IDX_IBASE_HI, IDX_CXBA, 7'h05};
  localparam logic [6:0] RI[4] = '{IDX_IBASE_LO, 7'h11, IDX_CXBA, 7'h05};
  logic        ref_clk, resetn, ptr_wr, data_wr, data_rd, rvalid;
  logic        tx_start, tx_frame_end, tx_fifo_empty, slot_elapsed;
  logic        chain_buf_miss, retransmit, tx_abort, status_wr, transmit_on;
  logic [15:0] wdata, rdata, status_word, r;
  wire logic   collision_pin, carrier_pin, link_fail_pin;
  int          errors, comparisons, aborts, retx, seed, k, n, base;
  txsr_exp_t   rq[$], sq[$];

  txsr_top #(.DIV(D), .ATTEMPTS(MAX_ATTEMPTS)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .ptr_wr(ptr_wr),
    .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid), .tx_start(tx_start),
    .tx_frame_end(tx_frame_end), .tx_fifo_empty(tx_fifo_empty),
    .slot_elapsed(slot_elapsed), .chain_buf_miss(chain_buf_miss),
    .collision_pin(collision_pin), .carrier_pin(carrier_pin),
    .link_fail_pin(link_fail_pin), .retransmit(retransmit),
    .tx_abort(tx_abort), .status_wr(status_wr),
    .status_word(status_word), .transmit_on(transmit_on));
  txsr_medium u_med (.ref_clk(ref_clk), .collision_pin(collision_pin),
    .carrier_pin(carrier_pin), .link_fail_pin(link_fail_pin));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic take(ref txsr_exp_t q[$], input logic [15:0] g, string s);
    txsr_exp_t e = '{16'h0000, 16'hffff, 0, 0};
    if (q.size() > 0)
      e = q.pop_front();
    chk(s, e.v, g & e.m);
    if (e.hi > 0)
      chk("distance", 16'h0001, 16'(g[9:0] >= e.lo && g[9:0] <= e.hi));
  endtask : take
  // Results are compared where they settle, away from the launch edge.
  always @(negedge ref_clk)
  begin
    aborts += (tx_abort === 1'b1);
    retx += (retransmit === 1'b1);
    if (rvalid === 1'b1)
      take(rq, rdata, "read");
    if (status_wr === 1'b1)
      take(sq, status_word, "status");
  end
  task setp(input logic [6:0] idx);
    ptr_wr = 1'b1;
    wdata = {9'h000, idx};
    tick();
    ptr_wr = 1'b0;
  endtask : setp
  task wreg(input logic [6:0] idx, input logic [15:0] v);
    setp(idx);
    data_wr = 1'b1;
    wdata = v;
    tick();
    data_wr = 1'b0;
  endtask : wreg
  task rreg(input logic [6:0] idx, input logic [15:0] m, v);
    setp(idx);
    data_rd = 1'b1;
    rq.push_back('{m, v & m, 0, 0});
    tick();
    data_rd = 1'b0;
    tick();
  endtask : rreg
  task stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task wait_on(input bit rt);
    for (k = 0; k < 400 && (rt ? retransmit : status_wr) !== 1'b1; k++)
      tick();
    if (k == 400)
    begin
      errors++;
      $display("BAD wait expected 1 seen 0");
      stop_test();
    end
  endtask : wait_on
  task start();
    wreg(IDX_STATUS, 16'h0010);
    tx_start = 1'b1;
    tick();
    tx_start = 1'b0;
  endtask : start
  task frame(input logic [15:0] v, input string s);
    sq.push_back('{16'hfc00, v, 0, 0});
    repeat (10) tick();
    tx_frame_end = 1'b1;
    tick();
    tx_frame_end = 1'b0;
    wait_on(1'b0);
    tick();
    $display("test %s done", s);
  endtask : frame

  initial
  begin
    {ptr_wr, data_wr, data_rd, tx_start, tx_frame_end} = '0;
    {tx_fifo_empty, slot_elapsed, chain_buf_miss} = '0;
    {errors, comparisons, aborts, retx} = '0;
    wdata = 16'h0000;
    seed = 32'h6a00;
    resetn = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    tick();
    rreg(IDX_STATUS, 16'h0010, STATUS_RST);
    rreg(IDX_MODE, 16'hffff, MODE_RST);
    for (n = 0; n < 4; n++)
    begin
      r = 16'($random(seed));
      wreg(WI[n], r);
      rreg(RI[n], 16'hffff, (n == 3) ? 16'h0000 : r);
    end
    u_med.set_carrier(1'b1);
    start();
    frame(16'h0000, "plain");
    n = aborts;
    start();
    u_med.set_carrier(1'b0);
    frame(16'h0800, "carrier");
    chk("aborts", 16'(n), 16'(aborts));
    u_med.set_carrier(1'b1);
    wreg(IDX_MODE, 16'h0080);
    u_med.set_link(1'b1);
    start();
    frame(16'h0800, "link");
    u_med.set_link(1'b0);
    wreg(IDX_MODE, 16'h0000);
    start();
    chk("transmit_on", 16'h0001, {15'h0000, transmit_on});
    sq.push_back('{16'hfc00, 16'h4000, 0, 0});
    tx_fifo_empty = 1'b1;
    wait_on(1'b0);
    tx_fifo_empty = 1'b0;
    tick();
    chk("transmit_on", 16'h0000, {15'h0000, transmit_on});
    start();
    sq.push_back('{16'hfc00, 16'hc000, 0, 0});
    chain_buf_miss = 1'b1;
    tick();
    chain_buf_miss = 1'b0;
    wait_on(1'b0);
    tick();
    n = retx;
    slot_elapsed = 1'b1;
    start();
    repeat (8 + ($random(seed) & 15)) tick();
    sq.push_back('{16'hfc00, 16'h1000, 0, 0});
    u_med.collide();
    wait_on(1'b0);
    slot_elapsed = 1'b0;
    tick();
    wreg(IDX_MODE, 16'h0020);
    start();
    repeat (40) tick();
    sq.push_back('{16'hfc00, 16'h0400, 40/D - 1, 40/D + 2});
    u_med.collide();
    wait_on(1'b0);
    tick();
    chk("retries", 16'(n), 16'(retx));
    wreg(IDX_MODE, 16'h0000);
    base = retx;
    start();
    for (n = 1; n <= MAX_ATTEMPTS; n++)
    begin
      repeat ((n == MAX_ATTEMPTS) ? 20 : 60) tick();
      if (n == MAX_ATTEMPTS)
        sq.push_back('{16'hfc00, 16'h0400, 20/D - 1, 20/D + 2});
      u_med.collide();
      wait_on(n < MAX_ATTEMPTS);
      tick();
      repeat (4) tick();
      tx_start = (n < MAX_ATTEMPTS);
      tick();
      tx_start = 1'b0;
    end
    chk("retries", 16'(MAX_ATTEMPTS - 1), 16'(retx - base));
    chk("queue", 16'h0000, 16'(sq.size() + rq.size()));
    stop_test();
  end
  initial
    k = 0;
endmodule : transmit_status_reporting_bench
